// ===== src/sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// register byte addresses: word index times four on the 32-bit bus
`define SAC_IDX_CSR        8'h2e
`define SAC_IDX_RESULT_HI  8'h2f
`define SAC_IDX_RESULT_LO  8'h30
`define SAC_IDX_CLKCTL     8'h31
`define SAC_ADDR_CSR       10'h0b8
`define SAC_ADDR_RESULT_HI 10'h0bc
`define SAC_ADDR_RESULT_LO 10'h0c0
`define SAC_ADDR_CLKCTL    10'h0c4

// control/status field positions
`define SAC_CSR_DONE_BIT   7
`define SAC_CSR_DIV_MSB    6
`define SAC_CSR_DIV_LSB    5
`define SAC_CSR_ON_BIT     4
`define SAC_CSR_CH_MSB     3
`define SAC_CSR_CH_LSB     0
// clock control field positions
`define SAC_CLK_IRQEN_BIT  0
`define SAC_CLK_STRETCH_BIT 1

`define SAC_CSR_RESET      8'h00
`define SAC_CLKCTL_RESET   8'h00

// timing: system clock and converter clock rates
`define SAC_SYS_CLK_MHZ    100
`define SAC_FADC0_MHZ      4
`define SAC_FADC1_MHZ      2
`define SAC_FADC2_MHZ      1
`define SAC_DIV0           (`SAC_SYS_CLK_MHZ / `SAC_FADC0_MHZ)
`define SAC_DIV1           (`SAC_SYS_CLK_MHZ / `SAC_FADC1_MHZ)
`define SAC_DIV2           (`SAC_SYS_CLK_MHZ / `SAC_FADC2_MHZ)
// sample phase: last phase count, one less than its length in converter clocks
`define SAC_SAMPLE_SHORT   4'h3
`define SAC_SAMPLE_LONG    4'hb

`endif

// ===== src/sac_pkg.sv
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SAMPLE = 2'b01,
    SAC_CONV   = 2'b10
  } sac_state_type;
endpackage : sac_pkg

// ===== src/sac_tick.sv
`timescale 1ns/1ps
`include "sac_map.svh"

// converter clock enable from the prescale field
module sac_tick (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_N,
  input  wire logic       run,
  input  wire logic [1:0] prescale,
  output logic            tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } sac_tick_state_type;

  sac_tick_state_type st_reg;
  sac_tick_state_type st_next;
  logic [6:0]         limit;

  always_comb begin
    case (prescale)
      2'b00:   limit = 7'(`SAC_DIV0 - 1);
      2'b01:   limit = 7'(`SAC_DIV1 - 1);
      default: limit = 7'(`SAC_DIV2 - 1);
    endcase
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = 7'h00;
    end else if (st_reg.cnt >= limit) begin
      st_next.cnt = 7'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 7'h01;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule : sac_tick

// ===== src/sac_ctrl.sv
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "sac_map.svh"

// Contract
// - 10-bit successive approximation with sample hold
// - result split across two byte registers
// - 4-bit channel select picks one of 16
// - converter_on starts continuous back-to-back conversions
// - done flag held low while converting (here cleared only on a start from idle or a high byte read)
// - channel change aborts and restarts conversion
// - done flag set at conversion end
// - interrupt only when conversion_irq_enable set
// - result held until next conversion finishes
// - reading high byte clears done flag
// - above high reference saturates to 3ff
// - below low reference gives zero
// - results are monotonic in input
// - stretch bit selects longer sample time
// - analog use keeps digital pin read
// - clearing converter_on stops conversion
// - low read locks results until release
// - bits 9:2 high, 1:0 low, rest zero
module sac_ctrl (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [9:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             WB_ERR_O,
  output logic      [3:0]  ANALOG_CH_SEL,
  output logic             ANALOG_SAMPLE,
  output logic      [9:0]  DAC_TRIAL,
  input  wire logic        ANALOG_COMP,
  input  wire logic [15:0] ANALOG_INPUT_PIN,
  output logic      [15:0] DIGITAL_PIN_VALUE,
  output logic             CONV_IRQ
);
  typedef struct packed {
    logic [7:0]            csr;
    logic [7:0]            clkctl;
    logic [9:0]            result;
    logic                  locked;
    sac_pkg::sac_state_type state;
    logic [3:0]            ch;
    logic [3:0]            phase_cnt;
    logic [3:0]            bit_idx;
    logic [9:0]            sar;
    logic [9:0]            trial;
    logic                  sample;
    logic                  comp_s1;
    logic                  comp_s2;
    logic [15:0]           pin_s1;
    logic [15:0]           pin_s2;
    logic                  ack;
    logic                  err;
    logic [31:0]           rdata;
    logic                  irq;
  } sac_ctrl_state_type;

  sac_ctrl_state_type st_reg;
  sac_ctrl_state_type st_next;
  logic               tick;
  logic               conv_on;
  logic [3:0]         ch_field;

  assign conv_on  = st_reg.csr[`SAC_CSR_ON_BIT];
  assign ch_field = st_reg.csr[`SAC_CSR_CH_MSB:`SAC_CSR_CH_LSB];

  sac_tick u_tick (
    .CLK_SYS  (CLK_SYS),
    .RST_N    (RST_N),
    .run      (conv_on),
    .prescale (st_reg.csr[`SAC_CSR_DIV_MSB:`SAC_CSR_DIV_LSB]),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       req;
    logic       wr;
    logic       rd_lo;
    logic       rd_hi;
    logic       restart;
    logic       finish;
    logic [9:0] trial;
    logic [9:0] final_code;
    logic       on_next;
    logic [3:0] ch_next;
    logic [3:0] sample_len;
    on_next    = 1'b0;
    ch_next    = 4'h0;
    sample_len = 4'h0;
    req        = 1'b0;
    wr         = 1'b0;
    rd_lo      = 1'b0;
    rd_hi      = 1'b0;
    restart    = 1'b0;
    finish     = 1'b0;
    trial      = 10'h000;
    final_code = 10'h000;
    st_next = st_reg;

    // comparator and pins come from the analog side: two stages first
    st_next.comp_s1 = ANALOG_COMP;
    st_next.comp_s2 = st_reg.comp_s1;
    st_next.pin_s1  = ANALOG_INPUT_PIN;
    st_next.pin_s2  = st_reg.pin_s1;

    // classic single-cycle slave: ack one cycle after strobe, dropped next cycle
    req = WB_CYC_I && WB_STB_I && !st_reg.ack && !st_reg.err;
    st_next.ack   = 1'b0;
    st_next.err   = 1'b0;
    st_next.rdata = 32'h0000_0000;
    if (req) begin
      wr = WB_WE_I && WB_SEL_I[0];
      case (WB_ADR_I)
        `SAC_ADDR_CSR: begin
          st_next.ack = 1'b1;
          st_next.rdata = {24'h000000, st_reg.csr};
          if (wr) begin
            // done flag is read only
            st_next.csr[6:0] = WB_DAT_I[6:0];
          end
        end
        `SAC_ADDR_RESULT_HI: begin
          st_next.ack = 1'b1;
          st_next.rdata = {24'h000000, st_reg.result[9:2]};
          rd_hi = !WB_WE_I;
        end
        `SAC_ADDR_RESULT_LO: begin
          st_next.ack = 1'b1;
          st_next.rdata = {24'h000000, 6'h00, st_reg.result[1:0]};
          rd_lo = !WB_WE_I;
        end
        `SAC_ADDR_CLKCTL: begin
          st_next.ack = 1'b1;
          st_next.rdata = {24'h000000, st_reg.clkctl};
          if (wr) begin
            st_next.clkctl = {6'h00, WB_DAT_I[1:0]};
          end
        end
        default: st_next.err = 1'b1;
      endcase
    end

    // lock on low read, release on high read or converter off
    if (rd_lo) begin
      st_next.locked = 1'b1;
    end
    on_next = st_next.csr[`SAC_CSR_ON_BIT];
    ch_next = st_next.csr[`SAC_CSR_CH_MSB:`SAC_CSR_CH_LSB];
    if (rd_hi || !on_next) begin
      st_next.locked = 1'b0;
    end

    // sample time follows the live setting, so a change applies to a sample already in progress
    sample_len = `SAC_SAMPLE_SHORT;
    if (st_reg.clkctl[`SAC_CLK_STRETCH_BIT]) begin
      sample_len = `SAC_SAMPLE_LONG;
    end
    trial   = st_reg.sar | (10'h200 >> st_reg.bit_idx);
    restart = ch_next != ch_field;

    case (st_reg.state)
      sac_pkg::SAC_IDLE: begin
        if (conv_on) begin
          st_next.state = sac_pkg::SAC_SAMPLE;
          st_next.ch = ch_field;
          st_next.phase_cnt = 4'h0;
        end
      end
      sac_pkg::SAC_SAMPLE: begin
        if (tick) begin
          if (st_reg.phase_cnt >= sample_len) begin
            st_next.state = sac_pkg::SAC_CONV;
            st_next.sar = 10'h000;
            st_next.bit_idx = 4'h0;
          end else begin
            st_next.phase_cnt = st_reg.phase_cnt + 4'h1;
          end
        end
      end
      sac_pkg::SAC_CONV: begin
        // binary search: keep a trial bit when input is at or above it,
        // which gives 3ff above top reference and 000 below bottom
        if (tick) begin
          if (st_reg.comp_s2) begin
            st_next.sar = trial;
          end
          if (st_reg.bit_idx == 4'h9) begin
            finish = 1'b1;
            final_code = st_reg.comp_s2 ? trial : st_reg.sar;
            st_next.state = sac_pkg::SAC_SAMPLE;
            st_next.ch = ch_field;
            st_next.phase_cnt = 4'h0;
          end else begin
            st_next.bit_idx = st_reg.bit_idx + 4'h1;
          end
        end
      end
      default: st_next.state = sac_pkg::SAC_IDLE;
    endcase

    if (finish && !restart) begin
      st_next.csr[`SAC_CSR_DONE_BIT] = 1'b1;
      if (!st_next.locked) begin
        st_next.result = final_code;
      end
    end else if (rd_hi) begin
      st_next.csr[`SAC_CSR_DONE_BIT] = 1'b0;
    end
    st_next.irq = finish && !restart && st_reg.clkctl[`SAC_CLK_IRQEN_BIT];

    if (restart && on_next) begin
      st_next.state = sac_pkg::SAC_SAMPLE;
      st_next.ch = ch_next;
      st_next.phase_cnt = 4'h0;
    end
    if (!on_next) begin
      st_next.state = sac_pkg::SAC_IDLE;
      st_next.sar = 10'h000;
    end
    // every start from idle, by the on bit or by a channel write, drops the flag
    if (st_next.state == sac_pkg::SAC_SAMPLE && st_reg.state == sac_pkg::SAC_IDLE) begin
      st_next.csr[`SAC_CSR_DONE_BIT] = 1'b0;
    end

    // analog strobes come straight from flops, in step with the state
    st_next.sample = st_next.state == sac_pkg::SAC_SAMPLE;
    st_next.trial  = 10'h000;
    if (st_next.state == sac_pkg::SAC_CONV) begin
      st_next.trial = st_next.sar | (10'h200 >> st_next.bit_idx);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
      st_reg.csr <= `SAC_CSR_RESET;
      st_reg.clkctl <= `SAC_CLKCTL_RESET;
      st_reg.state <= sac_pkg::SAC_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign WB_DAT_O          = st_reg.rdata;
  assign WB_ACK_O          = st_reg.ack;
  assign WB_ERR_O          = st_reg.err;
  assign ANALOG_CH_SEL     = st_reg.ch;
  assign ANALOG_SAMPLE     = st_reg.sample;
  assign DAC_TRIAL         = st_reg.trial;
  assign DIGITAL_PIN_VALUE = st_reg.pin_s2;
  assign CONV_IRQ          = st_reg.irq;
endmodule : sac_ctrl

// ===== tb/sac_analog_model.sv
`timescale 1ns/1ps
// ideal comparator behind the input mux; levels past either end clip naturally
module sac_analog_model (
  input  wire logic [3:0] ch,
  input  wire logic [9:0] trial,
  input  int              lvl [16],
  output logic            comp
);
  assign comp = lvl[ch] >= int'(trial);
endmodule : sac_analog_model

// ===== tb/sac_ctrl_props.sv
`timescale 1ns/1ps
module sac_ctrl_props (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic        WB_ERR_O,
  input wire logic [3:0]  ANALOG_CH_SEL,
  input wire logic        ANALOG_SAMPLE,
  input wire logic [9:0]  DAC_TRIAL,
  input wire logic [15:0] ANALOG_INPUT_PIN,
  input wire logic [15:0] DIGITAL_PIN_VALUE,
  input wire logic        CONV_IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_bus_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O
    |=> WB_ACK_O || WB_ERR_O) else $error("request not answered");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_err_excl: assert property (WB_ERR_O |-> !WB_ACK_O) else $error("ack with err");
  a_irq_pulse: assert property (CONV_IRQ |=> !CONV_IRQ) else $error("irq too long");
  a_irq_idle: assert property (CONV_IRQ |-> DAC_TRIAL == 10'h000)
    else $error("irq during approximation");
  a_sample_quiet: assert property (ANALOG_SAMPLE |-> DAC_TRIAL == 10'h000)
    else $error("trial during sample");
  a_chan_held: assert property (DAC_TRIAL != 10'h000 && $past(DAC_TRIAL) != 10'h000
    |-> $stable(ANALOG_CH_SEL)) else $error("channel moved mid conversion");
  a_first_trial: assert property ($fell(ANALOG_SAMPLE) && DAC_TRIAL != 10'h000
    |-> DAC_TRIAL == 10'h200) else $error("first trial not msb");
  a_pin_sync: assert property (DIGITAL_PIN_VALUE == $past(ANALOG_INPUT_PIN, 2))
    else $error("pin value lost");
  c_irq: cover property (CONV_IRQ);
  c_err: cover property (WB_ERR_O);
  c_conv: cover property ($fell(ANALOG_SAMPLE));
endmodule : sac_ctrl_props
bind sac_ctrl sac_ctrl_props u_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
  .ANALOG_CH_SEL(ANALOG_CH_SEL), .ANALOG_SAMPLE(ANALOG_SAMPLE), .DAC_TRIAL(DAC_TRIAL),
  .ANALOG_INPUT_PIN(ANALOG_INPUT_PIN), .DIGITAL_PIN_VALUE(DIGITAL_PIN_VALUE),
  .CONV_IRQ(CONV_IRQ));

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "sac_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module testbench;
  logic        clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, comp, ack, err, irq, samp, r;
  logic [9:0]  adr = 0, trial, x;
  logic [9:0]  exp_q [$];
  logic [31:0] wdat = 0, rdat, d;
  logic [3:0]  ch;
  logic [15:0] pins = 0, dpins;
  int          lvl [16];
  int          num_errors = 0, checked = 0, seed = 67808, i, n, e, k, dv;
  always #5 clk_sys = ~clk_sys;
  sac_ctrl dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WB_ERR_O(err), .ANALOG_CH_SEL(ch), .ANALOG_SAMPLE(samp),
    .DAC_TRIAL(trial), .ANALOG_COMP(comp), .ANALOG_INPUT_PIN(pins),
    .DIGITAL_PIN_VALUE(dpins), .CONV_IRQ(irq));
  sac_analog_model u_ana (.ch(ch), .trial(trial), .lvl(lvl), .comp(comp));
  ////////////////
  function automatic logic [9:0] sat(input int l);
    return l < 0 ? 10'h000 : l > 1023 ? 10'h3ff : l[9:0];
  endfunction : sat
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] v);
    int c;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h0, v};
    c = 0;
    do begin @(posedge clk_sys); c++; end while (ack !== 1'b1 && err !== 1'b1 && c < 50);
    d = rdat;
    r = err;
    if (c >= 50) num_errors++;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [9:0] a, input logic [7:0] xp);
    bus(0, a, 8'h00);
    `CHK(d[7:0], xp)
  endtask : rd
  // irq is the only completion cue visible without polling
  task automatic wait_irq;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (irq !== 1'b1 && n < 5000);
    `CHK(n < 5000, 1'b1)
  endtask : wait_irq
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #400_000;
    num_errors++;
    print_verdict();
  end
  ////////////////
  initial begin
    for (i = 0; i < 16; i++) lvl[i] = $random(seed) & 32'h3ff;
    lvl[0] = -7;
    lvl[15] = 4000;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rd(`SAC_ADDR_CSR, 8'h00);
    rd(`SAC_ADDR_RESULT_HI, 8'h00);
    rd(`SAC_ADDR_RESULT_LO, 8'h00);
    rd(`SAC_ADDR_CLKCTL, 8'h00);
    bus(0, 10'h3fc, 8'h00);
    `CHK(r, 1'b1)
    bus(1, `SAC_ADDR_RESULT_HI, 8'h5a);
    `CHK(r, 1'b0)
    rd(`SAC_ADDR_RESULT_HI, 8'h00);
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      e = i % 3;
      dv = e == 0 ? 25 : e == 1 ? 50 : 100;
      k = (i[0] ? 12 : 4) + 10;
      exp_q.push_back(sat(lvl[i]));
      x = exp_q.pop_front();
      pins <= $random(seed);
      bus(1, `SAC_ADDR_CLKCTL, {6'h0, i[0], 1'b1});
      bus(1, `SAC_ADDR_CSR, {1'b0, e[1:0], 1'b1, i[3:0]});
      wait_irq();
      `CHK(n >= (k - 1) * dv && n <= (k + 1) * dv + 4, 1'b1)
      `CHK(dpins, pins)
      rd(`SAC_ADDR_CSR, {1'b1, e[1:0], 1'b1, i[3:0]});
      rd(`SAC_ADDR_RESULT_LO, {6'h0, x[1:0]});
      rd(`SAC_ADDR_RESULT_HI, x[9:2]);
      rd(`SAC_ADDR_CSR, {1'b0, e[1:0], 1'b1, i[3:0]});
    end
    $display("test channels done");
    wait_irq();
    rd(`SAC_ADDR_RESULT_LO, 8'h03);
    lvl[15] <= 100;
    wait_irq();
    wait_irq();
    rd(`SAC_ADDR_RESULT_HI, 8'hff);
    wait_irq();
    rd(`SAC_ADDR_RESULT_LO, 8'h00);
    rd(`SAC_ADDR_RESULT_HI, 8'h19);
    $display("test lock done");
    bus(1, `SAC_ADDR_CSR, 8'h00);
    e = 0;
    repeat (1500) begin @(posedge clk_sys); if (irq === 1'b1 || samp === 1'b1) e++; end
    `CHK(e == 0, 1'b1)
    bus(1, `SAC_ADDR_CLKCTL, 8'h00);
    bus(1, `SAC_ADDR_CSR, 8'h13);
    repeat (1200) begin @(posedge clk_sys); if (irq === 1'b1) e++; end
    `CHK(e == 0, 1'b1)
    x = sat(lvl[3]);
    rd(`SAC_ADDR_CSR, 8'h93);
    rd(`SAC_ADDR_RESULT_HI, x[9:2]);
    $display("test off and mask done");
    print_verdict();
  end
endmodule : testbench
